// ===== vevdq_cfg.svh
`ifndef VEVDQ_CFG_SVH
`define VEVDQ_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define VEVDQ_OFS_VPRIM 8'h00
`define VEVDQ_OFS_VSEC 8'h04
`define VEVDQ_OFS_DCUR 8'h08
`define VEVDQ_OFS_QCUR 8'h0C
`define VEVDQ_OFS_UPD 8'h10

// ****************************************
// field positions and reset values
// ****************************************
`define VEVDQ_VOLT_MSB 15
`define VEVDQ_CUR_MSB 31
`define VEVDQ_UPD_MSB 3
`define VEVDQ_UPD_VPRIM 0
`define VEVDQ_UPD_VSEC 1
`define VEVDQ_UPD_DCUR 2
`define VEVDQ_UPD_QCUR 3
`define VEVDQ_RST_VOLT 16'h0000
`define VEVDQ_RST_CUR 32'h0000_0000
`define VEVDQ_RST_UPD 4'h0
`define VEVDQ_RST_WORD 32'h0000_0000

// ****************************************
// engine task numbers
// ****************************************
`define VEVDQ_TASK_IN_PROC_A 4'h2
`define VEVDQ_TASK_IN_PROC_B 4'hA
`define VEVDQ_TASK_IN_XFORM 4'h4
`define VEVDQ_TASK_CUR_CTRL 4'h5
`define VEVDQ_TASK_OUT_XFORM_A 4'h8
`define VEVDQ_TASK_OUT_XFORM_B 4'hB

// ****************************************
// bus encodings
// ****************************************
`define VEVDQ_HRESP_OKAY 1'b0
`define VEVDQ_ADDR_W 8

`endif

// ===== vevdq_pkg.sv
`include "vevdq_cfg.svh"

package vevdq_pkg;

    // ****************************************
    // engine task request
    // ****************************************
    typedef struct packed {
        logic strobe;
        logic [3:0] task_num;
    } vevdq_task_type;

    // store selection from the engine mode register
    typedef struct packed {
        logic store_primary;
        logic store_secondary;
    } vevdq_mode_type;

    // measured current pair
    typedef struct packed {
        logic [`VEVDQ_CUR_MSB:0] direct_current_value;
        logic [`VEVDQ_CUR_MSB:0] quadrature_current_value;
    } vevdq_dq_type;

    // ****************************************
    // complete block state
    // ****************************************
    typedef struct packed {
        logic [`VEVDQ_VOLT_MSB:0] vprim;
        logic [`VEVDQ_VOLT_MSB:0] vsec;
        logic [`VEVDQ_CUR_MSB:0] dcur;
        logic [`VEVDQ_CUR_MSB:0] qcur;
        logic [`VEVDQ_UPD_MSB:0] upd;
        logic dp_write;
        logic [`VEVDQ_ADDR_W-1:0] dp_addr;
        logic [31:0] rdata;
    } vevdq_state_type;

endpackage : vevdq_pkg

// ===== vevdq_regs.sv
// How it works
// - primary supply voltage is 16-bit unsigned fraction, upper 16 bits read zero
// - tasks 2 and 10 load primary voltage only when mode selects it
// - output phase transforms 8 and 11 use primary voltage as operand
// - secondary supply voltage uses same 16-bit unsigned fraction format
// - tasks 2 and 10 load secondary voltage only when mode selects it
// - d-axis current held as signed 32-bit fraction
// - q-axis current held as signed 32-bit fraction, same range
// - current scale is value times full-scale over two to the 31st
// - only task 4 writes d-axis and q-axis current registers; here bus writes to offsets 0x08 and 0x0C also load them
// - current control task 5 reads d and q currents as inputs
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "vevdq_cfg.svh"

module vevdq_regs
    import vevdq_pkg::*;
#(
    parameter int ADDR_W = `VEVDQ_ADDR_W
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // bus slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // engine side
    input wire vevdq_task_type engine_task,
    input wire vevdq_mode_type engine_mode_select,
    input wire logic [`VEVDQ_VOLT_MSB:0] supply_volt_value,
    input wire vevdq_dq_type xform_currents,
    output logic [`VEVDQ_VOLT_MSB:0] phase_xform_volt,
    output logic phase_xform_active,
    output logic [`VEVDQ_VOLT_MSB:0] supply_volt_alt_value,
    output vevdq_dq_type measured_currents,
    output logic cur_ctrl_active
);

    // ****************************************
    // helper functions
    // ****************************************

    // zero-extend a voltage field into a bus word
    function automatic logic [31:0] volt_word(input logic [`VEVDQ_VOLT_MSB:0] v);
        volt_word = {16'h0000, v};
    endfunction : volt_word

    // read multiplexer over one state image
    function automatic logic [31:0] read_word(
        input logic [ADDR_W-1:0] a,
        input vevdq_state_type s
    );
        logic [31:0] w;
        w = `VEVDQ_RST_WORD;
        unique case (a)
            `VEVDQ_OFS_VPRIM:
            begin
                w = volt_word(s.vprim);
            end
            `VEVDQ_OFS_VSEC:
            begin
                w = volt_word(s.vsec);
            end
            `VEVDQ_OFS_DCUR:
            begin
                w = s.dcur;
            end
            `VEVDQ_OFS_QCUR:
            begin
                w = s.qcur;
            end
            `VEVDQ_OFS_UPD:
            begin
                w = {28'h000_0000, s.upd};
            end
            default:
            begin
                w = `VEVDQ_RST_WORD;
            end
        endcase
        read_word = w;
    endfunction : read_word

    // true for the two input-processing tasks
    function automatic logic is_input_proc(input vevdq_task_type t);
        is_input_proc = t.strobe &&
            (t.task_num == `VEVDQ_TASK_IN_PROC_A || t.task_num == `VEVDQ_TASK_IN_PROC_B);
    endfunction : is_input_proc

    // ****************************************
    // state
    // ****************************************
    vevdq_state_type state_r;
    vevdq_state_type state_nxt;

    logic addr_phase;
    logic wr_vprim;
    logic wr_vsec;
    logic wr_dcur;
    logic wr_qcur;
    logic wr_upd;
    logic eng_vprim;
    logic eng_vsec;
    logic eng_dq;

    // ****************************************
    // bus decode
    // ****************************************

    // transfer taken only on a non-idle, selected, ready cycle
    assign addr_phase = hsel && hready && htrans[1] && clk_en;

    assign wr_vprim = state_r.dp_write && state_r.dp_addr == `VEVDQ_OFS_VPRIM;
    assign wr_vsec = state_r.dp_write && state_r.dp_addr == `VEVDQ_OFS_VSEC;
    assign wr_dcur = state_r.dp_write && state_r.dp_addr == `VEVDQ_OFS_DCUR;
    assign wr_qcur = state_r.dp_write && state_r.dp_addr == `VEVDQ_OFS_QCUR;
    assign wr_upd = state_r.dp_write && state_r.dp_addr == `VEVDQ_OFS_UPD;

    // ****************************************
    // engine task decode
    // ****************************************

    assign eng_vprim = is_input_proc(engine_task) && engine_mode_select.store_primary;

    assign eng_vsec = is_input_proc(engine_task) && engine_mode_select.store_secondary;

    assign eng_dq = engine_task.strobe && engine_task.task_num == `VEVDQ_TASK_IN_XFORM;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;

        // software writes first, engine overrides below
        if (wr_vprim)
        begin
            state_nxt.vprim = hwdata[`VEVDQ_VOLT_MSB:0];
        end
        if (wr_vsec)
        begin
            state_nxt.vsec = hwdata[`VEVDQ_VOLT_MSB:0];
        end
        if (wr_dcur)
        begin
            state_nxt.dcur = hwdata;
        end
        if (wr_qcur)
        begin
            state_nxt.qcur = hwdata;
        end
        if (wr_upd)
        begin
            // write one to clear
            state_nxt.upd = state_r.upd & ~hwdata[`VEVDQ_UPD_MSB:0];
        end

        if (eng_vprim)
        begin
            state_nxt.vprim = supply_volt_value;
            state_nxt.upd[`VEVDQ_UPD_VPRIM] = 1'b1;
        end
        if (eng_vsec)
        begin
            state_nxt.vsec = supply_volt_value;
            state_nxt.upd[`VEVDQ_UPD_VSEC] = 1'b1;
        end
        if (eng_dq)
        begin
            // task 4 stores d and q
            state_nxt.dcur = xform_currents.direct_current_value;
            state_nxt.qcur = xform_currents.quadrature_current_value;
            state_nxt.upd[`VEVDQ_UPD_DCUR] = 1'b1;
            state_nxt.upd[`VEVDQ_UPD_QCUR] = 1'b1;
        end

        // address phase capture
        if (addr_phase)
        begin
            state_nxt.dp_write = hwrite;
            state_nxt.dp_addr = haddr[ADDR_W-1:0];
        end
        else
        begin
            state_nxt.dp_write = 1'b0;
        end

        // read data sees this cycle's updates
        if (addr_phase && !hwrite)
        begin
            state_nxt.rdata = read_word(haddr[ADDR_W-1:0], state_nxt);
        end
        else if (addr_phase)
        begin
            state_nxt.rdata = `VEVDQ_RST_WORD;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r.vprim <= `VEVDQ_RST_VOLT;
            state_r.vsec <= `VEVDQ_RST_VOLT;
            state_r.dcur <= `VEVDQ_RST_CUR;
            state_r.qcur <= `VEVDQ_RST_CUR;
            state_r.upd <= `VEVDQ_RST_UPD;
            state_r.dp_write <= 1'b0;
            state_r.dp_addr <= '0;
            state_r.rdata <= `VEVDQ_RST_WORD;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // bus outputs
    // ****************************************

    // zero wait states, stalls only while frozen
    assign hreadyout = clk_en;
    assign hresp = `VEVDQ_HRESP_OKAY;
    assign hrdata = state_r.rdata;

    // ****************************************
    // engine outputs
    // ****************************************

    assign phase_xform_volt = state_r.vprim;
    assign phase_xform_active = engine_task.strobe &&
        (engine_task.task_num == `VEVDQ_TASK_OUT_XFORM_A ||
         engine_task.task_num == `VEVDQ_TASK_OUT_XFORM_B);

    assign supply_volt_alt_value = state_r.vsec;

    assign measured_currents.direct_current_value = state_r.dcur;
    assign measured_currents.quadrature_current_value = state_r.qcur;
    assign cur_ctrl_active = engine_task.strobe &&
        engine_task.task_num == `VEVDQ_TASK_CUR_CTRL;

endmodule : vevdq_regs

// ===== vevdq_props.sv
`include "vevdq_cfg.svh"
// ****
// register checks
// ****
module vevdq_props
    import vevdq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire vevdq_task_type engine_task,
    input wire vevdq_mode_type engine_mode_select,
    input wire logic [15:0] supply_volt_value,
    input wire vevdq_dq_type xform_currents,
    input wire logic [15:0] phase_xform_volt,
    input wire logic phase_xform_active,
    input wire logic [15:0] supply_volt_alt_value,
    input wire vevdq_dq_type measured_currents,
    input wire logic cur_ctrl_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic dp_r, dw_r, stb, in_t, wr_p, t4;
    logic [7:0] da_r;
    logic [3:0] tn;
    assign tn = engine_task.task_num;
    assign stb = engine_task.strobe && clk_en;
    assign in_t = stb && (tn == 4'h2 || tn == 4'hA);
    assign t4 = stb && tn == 4'h4;
    assign wr_p = dp_r && dw_r && hready;
    // data phase tracker
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            dp_r <= 1'b0;
            dw_r <= 1'b0;
            da_r <= 8'h00;
        end
        else if (hready)
        begin
            dp_r <= hsel && htrans[1];
            dw_r <= hwrite;
            da_r <= haddr[7:0];
        end
    end
    prim_load_a: assert property (in_t && engine_mode_select.store_primary |=>
        phase_xform_volt == $past(supply_volt_value)) else $error("primary load wrong");
    prim_hold_a: assert property (!(in_t && engine_mode_select.store_primary) &&
        !(wr_p && da_r == 8'h00) |=> $stable(phase_xform_volt)) else $error("primary moved");
    sec_load_a: assert property (in_t && engine_mode_select.store_secondary |=>
        supply_volt_alt_value == $past(supply_volt_value)) else $error("secondary load wrong");
    cur_load_a: assert property (t4 |=>
        measured_currents == $past(xform_currents)) else $error("current load wrong");
    cur_hold_a: assert property (!t4 && !(wr_p && da_r[7:3] == 5'h01) |=>
        $stable(measured_currents)) else $error("currents moved");
    engine_wins_a: assert property (t4 && wr_p && da_r == 8'h08 ##1 1'b1 |->
        measured_currents == $past(xform_currents)) else $error("bus beat engine");
    phase_act_a: assert property (phase_xform_active ==
        (engine_task.strobe && (tn == 4'h8 || tn == 4'hB))) else $error("phase active wrong");
    cur_act_a: assert property (cur_ctrl_active ==
        (engine_task.strobe && tn == 4'h5)) else $error("control active wrong");
    rd_upper_a: assert property (dp_r && !dw_r && hready && da_r[7:3] == 5'h00 |->
        hrdata[31:16] == 16'h0000) else $error("upper voltage bits set");
    cover property (in_t);
    cover property (wr_p);
    cover property (t4 && wr_p);
endmodule : vevdq_props

bind vevdq_regs vevdq_props u_props (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .engine_task(engine_task),
    .engine_mode_select(engine_mode_select), .supply_volt_value(supply_volt_value),
    .xform_currents(xform_currents), .phase_xform_volt(phase_xform_volt),
    .phase_xform_active(phase_xform_active), .supply_volt_alt_value(supply_volt_alt_value),
    .measured_currents(measured_currents), .cur_ctrl_active(cur_ctrl_active));

// ===== vevdq_tb.sv
// ****
// register block bench
// ****
module testbench
    import vevdq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, act;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, phase_xform_active, cur_ctrl_active;
    wire hready = hreadyout;
    vevdq_task_type engine_task = '0;
    vevdq_mode_type engine_mode_select = '0;
    logic [15:0] supply_volt_value = 16'h0, phase_xform_volt, supply_volt_alt_value;
    vevdq_dq_type xform_currents = '0, measured_currents;
    int mismatches = 0, n_compared = 0;
    logic [3:0] tl [6] = '{4'h2, 4'h5, 4'h8, 4'hB, 4'hA, 4'h0};
    logic [31:0] al [6] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h20};
    vevdq_regs dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .engine_task(engine_task), .engine_mode_select(engine_mode_select),
        .supply_volt_value(supply_volt_value), .xform_currents(xform_currents),
        .phase_xform_volt(phase_xform_volt), .phase_xform_active(phase_xform_active),
        .supply_volt_alt_value(supply_volt_alt_value), .measured_currents(measured_currents),
        .cur_ctrl_active(cur_ctrl_active));
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            mismatches++;
            results();
        end
    endtask : rdy
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic race);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (race)
            engine_task <= '{1'b1, 4'h4};
        rdy();
        rd = hrdata;
        chk("resp", 32'h0, {31'h0, hresp});
        if (race)
            engine_task.strobe <= 1'b0;
    endtask : bus
    task eng(input logic [3:0] t, input logic [1:0] m, input logic [15:0] v,
        input logic [63:0] c);
        engine_task <= '{1'b1, t};
        engine_mode_select <= m;
        supply_volt_value <= v;
        xform_currents <= c;
        @(posedge sys_clk);
        act = {phase_xform_active, cur_ctrl_active};
        engine_task.strobe <= 1'b0;
        @(posedge sys_clk);
    endtask : eng
    task t_reset;
        foreach (al[i])
        begin
            bus(1'b0, al[i], 32'h0, 1'b0);
            chk("reset read", 32'h0, rd);
        end
        chk("d out", 32'h0, measured_currents.direct_current_value);
        $display("test reset done");
    endtask : t_reset
    task t_volt;
        eng(4'h2, 2'b10, 16'h7FFF, 64'h0);
        chk("prim", 32'h7FFF, {16'h0, phase_xform_volt});
        chk("sec", 32'h0, {16'h0, supply_volt_alt_value});
        eng(4'hA, 2'b01, 16'h1234, 64'h0);
        chk("sec", 32'h1234, {16'h0, supply_volt_alt_value});
        eng(4'h2, 2'b00, 16'h5555, 64'h0);
        chk("prim", 32'h7FFF, {16'h0, phase_xform_volt});
        eng(4'h4, 2'b11, 16'h5555, 64'h0);
        chk("sec", 32'h1234, {16'h0, supply_volt_alt_value});
        bus(1'b0, 32'h0, 32'h0, 1'b0);
        chk("prim rd", 32'h7FFF, rd);
        bus(1'b1, 32'h4, 32'hFFFF_ABCD, 1'b0);
        bus(1'b0, 32'h4, 32'h0, 1'b0);
        chk("sec rd", 32'hABCD, rd);
        $display("test volt done");
    endtask : t_volt
    task t_cur;
        eng(4'h4, 2'b00, 16'h0, {32'h8000_0000, 32'h7FFF_FFFF});
        foreach (tl[i])
        begin
            eng(tl[i], 2'b11, 16'h0100, 64'h1111_2222_3333_4444);
            chk("act", {tl[i] == 4'h8 || tl[i] == 4'hB, tl[i] == 4'h5}, act);
            chk("q out", 32'h7FFF_FFFF, measured_currents.quadrature_current_value);
        end
        bus(1'b0, 32'h8, 32'h0, 1'b0);
        chk("d rd", 32'h8000_0000, rd);
        bus(1'b0, 32'hC, 32'h0, 1'b0);
        chk("q rd", 32'h7FFF_FFFF, rd);
        bus(1'b0, 32'h10, 32'h0, 1'b0);
        chk("upd", 32'hF, rd);
        bus(1'b1, 32'h10, 32'hF, 1'b0);
        bus(1'b0, 32'h10, 32'h0, 1'b0);
        chk("upd clr", 32'h0, rd);
        $display("test current done");
    endtask : t_cur
    task t_race;
        xform_currents <= {32'h0BAD_F00D, 32'h0};
        bus(1'b1, 32'h8, 32'hDEAD_0000, 1'b1);
        bus(1'b0, 32'h8, 32'h0, 1'b0);
        chk("race", 32'h0BAD_F00D, rd);
        clk_en <= 1'b0;
        engine_task <= '{1'b1, 4'h4};
        xform_currents <= 64'h0;
        @(posedge sys_clk);
        chk("stall", 32'h0, {31'h0, hreadyout});
        engine_task.strobe <= 1'b0;
        clk_en <= 1'b1;
        @(posedge sys_clk);
        chk("frozen", 32'h0BAD_F00D, measured_currents.direct_current_value);
        $display("test race done");
    endtask : t_race
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_volt();
        t_cur();
        t_race();
        results();
    end
endmodule : testbench
